// File: rtl/lmme_defines.vh
`ifndef LMME_DEFINES_VH
`define LMME_DEFINES_VH
// immediate-type opcode field values, then the register-type opcode
`define LMME_OP_LDHU 6'h0B
`define LMME_OP_LDHUIO 6'h2B
`define LMME_OP_LDW 6'h17
`define LMME_OP_LDWIO 6'h37
`define LMME_OP_ORI 6'h14
`define LMME_OP_ORHI 6'h34
`define LMME_OP_ADDI 6'h04
`define LMME_OP_MULI 6'h24
`define LMME_OP_RTYPE 6'h3A
// register-type extended opcode values
`define LMME_OPX_ADD 6'h31
`define LMME_OPX_MUL 6'h27
`define LMME_OPX_MULXUU 6'h07
// field positions
`define LMME_A_HI 31
`define LMME_A_LO 27
`define LMME_B_HI 26
`define LMME_B_LO 22
`define LMME_C_HI 21
`define LMME_C_LO 17
`define LMME_OPX_HI 16
`define LMME_OPX_LO 11
`define LMME_IMM_HI 21
`define LMME_IMM_LO 6
`define LMME_OP_HI 5
`define LMME_OP_LO 0
// exception cause codes
`define LMME_EXC_NONE 3'h0
`define LMME_EXC_SUPER 3'h1
`define LMME_EXC_MISALIGN 3'h2
`define LMME_EXC_PERM 3'h3
`define LMME_EXC_FAST_MISS 3'h4
`define LMME_EXC_DOUBLE_MISS 3'h5
`define LMME_EXC_REGION 3'h6
`define LMME_EXC_UNIMPL 3'h7
`endif

// File: rtl/lmme_ext.v
`timescale 1ns/1ps
// ****************************************
// immediate extension
// ****************************************
module lmme_ext (
    input wire [15:0] i_short_immediate_field,
    input wire i_signed,
    input wire i_high,
    output wire [31:0] o_immediate_operand
);
    assign o_immediate_operand = i_high ? {i_short_immediate_field, 16'h0000} :
        {{16{i_signed & i_short_immediate_field[15]}}, i_short_immediate_field};
endmodule // lmme_ext

// File: rtl/lmme_mul.v
`timescale 1ns/1ps
// ****************************************
// 32x32 unsigned multiplier
// ****************************************
module lmme_mul (
    input wire [31:0] i_a,
    input wire [31:0] i_b,
    output wire [31:0] o_low,
    output wire [31:0] o_high
);
    wire [63:0] product;
    // low word is sign-agnostic, so one unsigned product serves both
    assign product = {32'h00000000, i_a} * {32'h00000000, i_b};
    assign o_low = product[31:0];
    assign o_high = product[63:32];
endmodule // lmme_mul

// File: rtl/lmme_exec.v
`timescale 1ns/1ps
`include "lmme_defines.vh"
// Function
// - halfword address is A plus signed immediate
// - halfword load zero-extends into register B
// - ordinary loads may hit the cache
// - bypass loads always go to bus
// - without cache bypass equals ordinary load
// - loads report the six memory exceptions
// - opcode 0B is unsigned halfword load
// - opcode 2B is bypass halfword load
// - word load writes whole word
// - opcode 17 is word load
// - high move places immediate in top half
// - signed move sign-extends immediate
// - unsigned move zero-extends immediate
// - register move adds A and zero
// - multiply writes low product word
// - no multiplier raises unimplemented exception
// - immediate multiply uses signed immediate
// - high multiply nonzero on unsigned overflow
// - high multiply writes upper product word
module lmme_exec #(
    parameter HAS_DCACHE = 1,
    parameter HAS_MUL = 1
) (
    input wire i_clock,
    input wire i_rst,
    input wire i_valid,
    input wire [31:0] i_instr,
    input wire [31:0] i_reg_a,
    input wire [31:0] i_reg_b,
    input wire i_supervisor,
    input wire i_super_only,
    input wire i_read_denied,
    input wire i_fast_miss,
    input wire i_double_miss,
    input wire i_region_fault,
    input wire i_mem_ready,
    input wire [31:0] i_mem_rdata,
    output reg o_mem_read,
    output reg o_mem_bypass,
    output reg [31:0] o_mem_addr,
    output reg [3:0] o_mem_byteen,
    output reg o_busy,
    output reg o_wr_en,
    output reg [4:0] o_wr_index,
    output reg [31:0] o_wr_data,
    output reg o_exc,
    output reg [2:0] o_exc_cause
);
    // ****************************************
    // decode
    // ****************************************
    localparam ST_IDLE = 1'b0;
    localparam ST_LOAD = 1'b1;

    wire [5:0] op = i_instr[`LMME_OP_HI:`LMME_OP_LO];
    wire [5:0] opx = i_instr[`LMME_OPX_HI:`LMME_OPX_LO];
    wire [4:0] idx_b = i_instr[`LMME_B_HI:`LMME_B_LO];
    wire [4:0] idx_c = i_instr[`LMME_C_HI:`LMME_C_LO];
    wire [15:0] short_immediate_field = i_instr[`LMME_IMM_HI:`LMME_IMM_LO];

    function is_op;
        input [5:0] value;
        input [5:0] code;
        begin
            is_op = (value == code);
        end
    endfunction

    wire dec_ldhu = is_op(op, `LMME_OP_LDHU);
    wire dec_ldhuio = is_op(op, `LMME_OP_LDHUIO);
    wire dec_ldw = is_op(op, `LMME_OP_LDW);
    wire dec_ldwio = is_op(op, `LMME_OP_LDWIO);
    wire dec_ori = is_op(op, `LMME_OP_ORI);
    wire dec_orhi = is_op(op, `LMME_OP_ORHI);
    wire dec_addi = is_op(op, `LMME_OP_ADDI);
    wire dec_muli = is_op(op, `LMME_OP_MULI);
    wire dec_r = is_op(op, `LMME_OP_RTYPE);
    wire dec_add = dec_r & is_op(opx, `LMME_OPX_ADD);
    wire dec_mul = dec_r & is_op(opx, `LMME_OPX_MUL);
    wire dec_mulxuu = dec_r & is_op(opx, `LMME_OPX_MULXUU);
    wire dec_half = dec_ldhu | dec_ldhuio;
    wire dec_load = dec_half | dec_ldw | dec_ldwio;
    wire dec_io = dec_ldhuio | dec_ldwio;

    // ****************************************
    // operands
    // ****************************************
    wire [31:0] imm_sext;
    wire [31:0] imm_zext;
    wire [31:0] imm_high;
    wire [31:0] immediate_operand;
    wire [31:0] mul_low;
    wire [31:0] mul_high;
    wire [31:0] eff_addr;

    lmme_ext u_ext_s (
        .i_short_immediate_field(short_immediate_field),
        .i_signed(1'b1),
        .i_high(1'b0),
        .o_immediate_operand(imm_sext)
    );
    lmme_ext u_ext_z (
        .i_short_immediate_field(short_immediate_field),
        .i_signed(1'b0),
        .i_high(1'b0),
        .o_immediate_operand(imm_zext)
    );
    lmme_ext u_ext_h (
        .i_short_immediate_field(short_immediate_field),
        .i_signed(1'b0),
        .i_high(1'b1),
        .o_immediate_operand(imm_high)
    );

    assign immediate_operand = dec_muli ? imm_sext : i_reg_b;
    assign eff_addr = i_reg_a + imm_sext;

    lmme_mul u_mul (
        .i_a(i_reg_a),
        .i_b(immediate_operand),
        .o_low(mul_low),
        .o_high(mul_high)
    );

    // ****************************************
    // exception check for loads
    // ****************************************
    wire misaligned = dec_half ? eff_addr[0] : (eff_addr[1] | eff_addr[0]);
    reg [2:0] load_cause;
    always @* begin
        // priority: privilege, alignment, translation, protection
        load_cause = `LMME_EXC_NONE;
        if (i_super_only & ~i_supervisor) begin
            load_cause = `LMME_EXC_SUPER;
        end else if (misaligned) begin
            load_cause = `LMME_EXC_MISALIGN;
        end else if (i_double_miss) begin
            load_cause = `LMME_EXC_DOUBLE_MISS;
        end else if (i_fast_miss) begin
            load_cause = `LMME_EXC_FAST_MISS;
        end else if (i_read_denied) begin
            load_cause = `LMME_EXC_PERM;
        end else if (i_region_fault) begin
            load_cause = `LMME_EXC_REGION;
        end
    end

    // ****************************************
    // instruction class
    // ****************************************
    localparam K_NONE = 3'h0;
    localparam K_LOAD = 3'h1;
    localparam K_MUL = 3'h2;
    localparam K_ORHI = 3'h3;
    localparam K_ADDI = 3'h4;
    localparam K_ORI = 3'h5;
    localparam K_ADD = 3'h6;

    reg [2:0] kind;
    always @* begin
        // opcodes outside this subset stay unclassified and are ignored
        kind = K_NONE;
        if (dec_load) begin
            kind = K_LOAD;
        end else if (dec_mul | dec_muli | dec_mulxuu) begin
            kind = K_MUL;
        end else if (dec_orhi) begin
            kind = K_ORHI;
        end else if (dec_addi) begin
            kind = K_ADDI;
        end else if (dec_ori) begin
            kind = K_ORI;
        end else if (dec_add) begin
            kind = K_ADD;
        end
    end

    // ****************************************
    // load data extension
    // ****************************************
    function [31:0] load_extend;
        input [31:0] word;
        input half;
        input hi_lane;
        begin
            // odd halfword addresses are trapped before issue, never loaded
            if (half) begin
                load_extend = {16'h0000, hi_lane ? word[31:16] : word[15:0]};
            end else begin
                load_extend = word;
            end
        end
    endfunction

    // ****************************************
    // execute: next values
    // ****************************************
    reg state;
    reg load_half;
    reg load_hi_lane;
    reg [4:0] load_index;
    reg next_state;
    reg next_load_half;
    reg next_load_hi_lane;
    reg [4:0] next_load_index;
    reg next_mem_read;
    reg next_mem_bypass;
    reg [31:0] next_mem_addr;
    reg [3:0] next_mem_byteen;
    reg next_busy;
    reg next_wr_en;
    reg [4:0] next_wr_index;
    reg [31:0] next_wr_data;
    reg next_exc;
    reg [2:0] next_exc_cause;

    always @* begin
        // pulses fall by default; every other output holds its value
        next_state = state;
        next_load_half = load_half;
        next_load_hi_lane = load_hi_lane;
        next_load_index = load_index;
        next_mem_read = o_mem_read;
        next_mem_bypass = o_mem_bypass;
        next_mem_addr = o_mem_addr;
        next_mem_byteen = o_mem_byteen;
        next_busy = o_busy;
        next_wr_en = 1'b0;
        next_wr_index = o_wr_index;
        next_wr_data = o_wr_data;
        next_exc = 1'b0;
        next_exc_cause = o_exc_cause;
        case (state)
            ST_IDLE: begin
                if (i_valid) begin
                    case (kind)
                        K_LOAD: begin
                            if (load_cause != `LMME_EXC_NONE) begin
                                next_exc = 1'b1;
                                next_exc_cause = load_cause;
                            end else begin
                                // the cache decides hits; bypass forces a bus cycle
                                next_mem_read = 1'b1;
                                next_mem_bypass = (HAS_DCACHE != 0) & dec_io;
                                next_mem_addr = {eff_addr[31:2], 2'h0};
                                next_mem_byteen = dec_half ? (eff_addr[1] ? 4'hC : 4'h3) : 4'hF;
                                next_load_half = dec_half;
                                next_load_hi_lane = eff_addr[1];
                                next_load_index = idx_b;
                                next_busy = 1'b1;
                                next_state = ST_LOAD;
                            end
                        end
                        K_MUL: begin
                            if (HAS_MUL == 0) begin
                                next_exc = 1'b1;
                                next_exc_cause = `LMME_EXC_UNIMPL;
                            end else begin
                                next_wr_en = 1'b1;
                                next_wr_index = dec_muli ? idx_b : idx_c;
                                // upper word is nonzero exactly on unsigned overflow
                                next_wr_data = dec_mulxuu ? mul_high : mul_low;
                            end
                        end
                        K_ORHI: begin
                            next_wr_en = 1'b1;
                            next_wr_index = idx_b;
                            next_wr_data = i_reg_a | imm_high;
                        end
                        K_ADDI: begin
                            next_wr_en = 1'b1;
                            next_wr_index = idx_b;
                            next_wr_data = i_reg_a + imm_sext;
                        end
                        K_ORI: begin
                            next_wr_en = 1'b1;
                            next_wr_index = idx_b;
                            next_wr_data = i_reg_a | imm_zext;
                        end
                        K_ADD: begin
                            next_wr_en = 1'b1;
                            next_wr_index = idx_c;
                            next_wr_data = i_reg_a + i_reg_b;
                        end
                        default: begin
                            next_wr_en = 1'b0;
                        end
                    endcase
                end
            end
            ST_LOAD: begin
                if (i_mem_ready) begin
                    next_mem_read = 1'b0;
                    next_mem_bypass = 1'b0;
                    next_busy = 1'b0;
                    next_wr_en = 1'b1;
                    next_wr_index = load_index;
                    next_wr_data = load_extend(i_mem_rdata, load_half, load_hi_lane);
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // execute: registers
    // ****************************************
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_IDLE;
            load_half <= 1'b0;
            load_hi_lane <= 1'b0;
            load_index <= 5'h00;
            o_mem_read <= 1'b0;
            o_mem_bypass <= 1'b0;
            o_mem_addr <= 32'h00000000;
            o_mem_byteen <= 4'h0;
            o_busy <= 1'b0;
            o_wr_en <= 1'b0;
            o_wr_index <= 5'h00;
            o_wr_data <= 32'h00000000;
            o_exc <= 1'b0;
            o_exc_cause <= `LMME_EXC_NONE;
        end else begin
            state <= next_state;
            load_half <= next_load_half;
            load_hi_lane <= next_load_hi_lane;
            load_index <= next_load_index;
            o_mem_read <= next_mem_read;
            o_mem_bypass <= next_mem_bypass;
            o_mem_addr <= next_mem_addr;
            o_mem_byteen <= next_mem_byteen;
            o_busy <= next_busy;
            o_wr_en <= next_wr_en;
            o_wr_index <= next_wr_index;
            o_wr_data <= next_wr_data;
            o_exc <= next_exc;
            o_exc_cause <= next_exc_cause;
        end
    end
endmodule // lmme_exec

// File: testbench/lmme_exec_props.sv
`timescale 1ns/1ps
module lmme_exec_props #(
    parameter HAS_DCACHE = 1,
    parameter HAS_MUL = 1
) (
    input wire i_clock, input wire i_rst, input wire i_valid,
    input wire [31:0] i_instr, input wire [31:0] i_reg_a, input wire [31:0] i_reg_b,
    input wire i_supervisor, input wire i_super_only, input wire i_read_denied,
    input wire i_fast_miss, input wire i_double_miss, input wire i_region_fault,
    input wire i_mem_ready, input wire [31:0] i_mem_rdata,
    input wire o_mem_read, input wire o_mem_bypass, input wire [31:0] o_mem_addr,
    input wire [3:0] o_mem_byteen, input wire o_busy, input wire o_wr_en,
    input wire [4:0] o_wr_index, input wire [31:0] o_wr_data,
    input wire o_exc, input wire [2:0] o_exc_cause
);
    // ****************
    // decode helpers
    // ****************
    wire [5:0] op = i_instr[5:0];
    wire [5:0] opx = i_instr[16:11];
    wire [4:0] ci = i_instr[21:17];
    wire io = op[5];
    wire take = i_valid && !o_busy;
    wire half = op[4:0] == 5'h0B;
    wire ld = half || op[4:0] == 5'h17;
    wire [31:0] si = {{16{i_instr[21]}}, i_instr[21:6]};
    wire [31:0] ea = i_reg_a + si;
    wire [31:0] wa = {ea[31:2], 2'h0};
    wire mis = half ? ea[0] : (ea[1:0] != 2'h0);
    wire sf = i_super_only && !i_supervisor;
    // a fault on any lookup blocks the bus read
    wire ok = !sf && !mis && !i_read_denied && !i_fast_miss && !i_double_miss && !i_region_fault;
    wire [63:0] pp = i_reg_a * i_reg_b;
    wire [31:0] pl = pp[31:0];
    wire [31:0] ph = pp[63:32];
    wire [31:0] pi = i_reg_a * si;
    wire [15:0] lane = o_mem_byteen[3] ? i_mem_rdata[31:16] : i_mem_rdata[15:0];
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // ****************
    // properties
    // ****************
    property p_addr; take && ld && ok |=> o_mem_read && o_mem_addr == $past(wa); endproperty
    a_addr: assert property (p_addr) else $error("load address wrong");
    property p_io; take && ld && ok |=> o_mem_bypass == ($past(io) && HAS_DCACHE != 0); endproperty
    a_io: assert property (p_io) else $error("bypass flag wrong");
    property p_hold; o_mem_read && !i_mem_ready |=> o_mem_read && $stable(o_mem_addr); endproperty
    a_hold: assert property (p_hold) else $error("read dropped early");
    property p_ldw;
        o_mem_read && i_mem_ready && o_mem_byteen == 4'hF |=> o_wr_en && o_wr_data == $past(i_mem_rdata);
    endproperty
    a_ldw: assert property (p_ldw) else $error("word data wrong");
    property p_ldh;
        o_mem_read && i_mem_ready && o_mem_byteen != 4'hF |=> o_wr_en && o_wr_data == {16'h0000, $past(lane)};
    endproperty
    a_ldh: assert property (p_ldh) else $error("halfword data wrong");
    property p_mis; take && ld && mis && !sf |=> o_exc && o_exc_cause == 3'h2; endproperty
    a_mis: assert property (p_mis) else $error("misalign not flagged");
    property p_mul;
        HAS_MUL != 0 && take && op == 6'h3A && opx == 6'h27 |=>
            o_wr_en && o_wr_data == $past(pl) && o_wr_index == $past(ci);
    endproperty
    a_mul: assert property (p_mul) else $error("mul result wrong");
    property p_muli; HAS_MUL != 0 && take && op == 6'h24 |=> o_wr_en && o_wr_data == $past(pi); endproperty
    a_muli: assert property (p_muli) else $error("muli result wrong");
    property p_hi;
        HAS_MUL != 0 && take && op == 6'h3A && opx == 6'h07 |=> o_wr_en && o_wr_data == $past(ph);
    endproperty
    a_hi: assert property (p_hi) else $error("high product wrong");
    wire mulop = op == 6'h24 || (op == 6'h3A && (opx == 6'h27 || opx == 6'h07));
    property p_unimpl; HAS_MUL == 0 && take && mulop |=> o_exc && o_exc_cause == 3'h7; endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented not raised");
    c_trap: cover property (o_exc && o_exc_cause == 3'h7);
    c_load: cover property (take && ld && ok);
    c_exc: cover property (o_exc);
    c_wait: cover property (o_mem_read && !i_mem_ready);
endmodule // lmme_exec_props
bind lmme_exec lmme_exec_props #(.HAS_DCACHE(HAS_DCACHE), .HAS_MUL(HAS_MUL)) i_props (.*);

// File: testbench/lmme_mem.sv
`timescale 1ns/1ps
// ****************
// data memory with wait states
// ****************
module lmme_mem (
    input wire i_clock, input wire i_rst, input wire i_read,
    input wire [31:0] i_addr, input wire [3:0] i_wait,
    output reg o_ready, output reg [31:0] o_rdata
);
    reg [3:0] cnt;
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cnt <= 4'h0;
            o_ready <= 1'b0;
            o_rdata <= 32'h0;
        end else begin
            // data toggles when not answering so stale values never match
            o_rdata <= ~o_rdata;
            o_ready <= 1'b0;
            if (i_read && !o_ready) begin
                if (cnt == i_wait) begin
                    cnt <= 4'h0;
                    o_ready <= 1'b1;
                    o_rdata <= {~i_addr[15:0], i_addr[15:0]};
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule // lmme_mem

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    reg i_clock, i_rst, v, sw, se, lby;
    reg sv, sw2, se2, lby2;
    wire we2, ex2, mb2;
    wire [31:0] wd2;
    wire [2:0] ec2;
    reg [31:0] ins, ra, rb, la;
    reg [4:0] f;
    reg [3:0] wt, lbe;
    reg [127:0] tab [0:6];
    integer errors, checked, n, k;
    integer cyc = 0;
    wire mr, mb, bz, we, ex, rdy;
    wire [31:0] ma, wd, md;
    wire [3:0] be;
    wire [4:0] wi;
    wire [2:0] ec;
    lmme_exec i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_valid(v), .i_instr(ins),
        .i_reg_a(ra), .i_reg_b(rb), .i_supervisor(sv), .i_super_only(f[0]),
        .i_read_denied(f[1]), .i_fast_miss(f[2]), .i_double_miss(f[3]),
        .i_region_fault(f[4]), .i_mem_ready(rdy), .i_mem_rdata(md), .o_mem_read(mr),
        .o_mem_bypass(mb), .o_mem_addr(ma), .o_mem_byteen(be), .o_busy(bz), .o_wr_en(we),
        .o_wr_index(wi), .o_wr_data(wd), .o_exc(ex), .o_exc_cause(ec));
    lmme_mem i_mem (.i_clock(i_clock), .i_rst(i_rst), .i_read(mr), .i_addr(ma),
        .i_wait(wt), .o_ready(rdy), .o_rdata(md));
    // no cache, no multiplier: bypass loads act as ordinary ones, multiplies trap
    lmme_exec #(.HAS_DCACHE(0), .HAS_MUL(0)) i_dut_lite (.i_clock(i_clock), .i_rst(i_rst),
        .i_valid(v), .i_instr(ins), .i_reg_a(ra), .i_reg_b(rb), .i_supervisor(sv),
        .i_super_only(f[0]), .i_read_denied(f[1]), .i_fast_miss(f[2]), .i_double_miss(f[3]),
        .i_region_fault(f[4]), .i_mem_ready(rdy), .i_mem_rdata(md), .o_mem_read(),
        .o_mem_bypass(mb2), .o_mem_addr(), .o_mem_byteen(), .o_busy(), .o_wr_en(we2),
        .o_wr_index(), .o_wr_data(wd2), .o_exc(ex2), .o_exc_cause(ec2));
    function [31:0] fi(input [4:0] a, input [4:0] b, input [15:0] m, input [5:0] o);
        fi = {a, b, m, o};
    endfunction
    function [31:0] fr(input [4:0] a, input [4:0] b, input [4:0] c, input [5:0] x);
        fr = {a, b, c, x, 5'h00, 6'h3A};
    endfunction
    task chk(input c, input [95:0] m);
        begin
            checked = checked + 1;
            if (!c) begin
                errors = errors + 1;
                $display("mismatch at %0t: %0s", $time, m);
            end
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d errors %0d", checked, errors);
            if (errors == 0 && checked > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    // one issue, then wait for the write or exception pulse and capture the bus request
    task go(input [31:0] i, input [31:0] a, input [31:0] b);
        begin
            ins = i;
            ra = a;
            rb = b;
            v = 1'b1;
            la = 32'h0;
            lbe = 4'h0;
            lby = 1'b0;
            lby2 = 1'b1;
            @(posedge i_clock);
            #1 v = 1'b0;
            n = 0;
            while (we !== 1'b1 && ex !== 1'b1 && n < 20) begin
                if (mr === 1'b1) begin
                    la = ma;
                    lbe = be;
                    lby = mb;
                    lby2 = mb2;
                end
                @(posedge i_clock);
                #1 n = n + 1;
            end
            sw = we;
            se = ex;
            sw2 = we2;
            se2 = ex2;
            @(posedge i_clock);
            #1;
        end
    endtask
    task ld(input [31:0] i, input [31:0] a, input [31:0] x, input [31:0] d,
        input [3:0] e, input y);
        begin
            go(i, a, 32'h0);
            chk(sw === 1'b1 && wd === d && wi === 5'h06, "ld data");
            chk(la === x && lbe === e && lby === y, "ld bus");
            chk(sw2 === 1'b1 && wd2 === d && lby2 === 1'b0, "lite ld");
        end
    endtask
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cyc = cyc + 1;
        if (cyc == 1000) begin
            errors = errors + 1;
            end_sim;
        end
    end
    initial begin
        errors = 0;
        checked = 0;
        i_rst = 1'b1;
        {v, sv, ins, ra, rb, f, wt, sw, se} = 0;
        tab[0] = {fi(5'h00, 5'h06, 16'h8000, 6'h34), 32'h0, 32'h0, 32'h80000000};
        tab[1] = {fi(5'h00, 5'h06, 16'hFFE2, 6'h04), 32'h0, 32'h0, 32'hFFFFFFE2};
        tab[2] = {fi(5'h00, 5'h06, 16'hFFFF, 6'h14), 32'h0, 32'h0, 32'h0000FFFF};
        tab[3] = {fr(5'h07, 5'h00, 5'h06, 6'h31), 32'h12345678, 32'h0, 32'h12345678};
        tab[4] = {fr(5'h07, 5'h08, 5'h06, 6'h27), 32'hFFFFFFFF, 32'h3, 32'hFFFFFFFD};
        tab[5] = {fi(5'h07, 5'h06, 16'hFF9C, 6'h24), 32'h5, 32'h0, 32'hFFFFFE0C};
        tab[6] = {fr(5'h07, 5'h08, 5'h06, 6'h07), 32'h80000000, 32'h4, 32'h2};
        repeat (8) @(posedge i_clock);
        chk(we === 1'b0 && ex === 1'b0 && mr === 1'b0 && bz === 1'b0 && wd === 32'h0, "reset");
        $display("reset test done");
        #1 i_rst = 1'b0;
        for (k = 0; k < 7; k = k + 1) begin
            go(tab[k][127:96], tab[k][95:64], tab[k][63:32]);
            chk(sw === 1'b1 && wd === tab[k][31:0] && wi === 5'h06, "table");
            chk(k < 4 ? (sw2 === 1'b1 && wd2 === tab[k][31:0]) : (se2 === 1'b1 && ec2 === 3'h7), "lite");
        end
        $display("table test done");
        ld(fi(5'h01, 5'h06, 16'hFFFE, 6'h0B), 32'h1000, 32'h0FFC, 32'h0000F003, 4'hC, 1'b0);
        ld(fi(5'h01, 5'h06, 16'h0004, 6'h2B), 32'h2000, 32'h2004, 32'h00002004, 4'h3, 1'b1);
        wt = 4'h3;
        ld(fi(5'h01, 5'h06, 16'h0008, 6'h17), 32'h3000, 32'h3008, 32'hCFF73008, 4'hF, 1'b0);
        ld(fi(5'h01, 5'h06, 16'h0010, 6'h37), 32'h3000, 32'h3010, 32'hCFEF3010, 4'hF, 1'b1);
        $display("load test done");
        go(fi(5'h01, 5'h06, 16'h0001, 6'h0B), 32'h1000, 32'h0);
        chk(se === 1'b1 && ec === 3'h2 && sw === 1'b0, "misalign");
        go(fi(5'h01, 5'h06, 16'h0002, 6'h17), 32'h3000, 32'h0);
        chk(se === 1'b1 && ec === 3'h2 && sw === 1'b0, "misalign");
        for (k = 0; k < 5; k = k + 1) begin
            f = 5'h01 << k;
            go(fi(5'h01, 5'h06, 16'h0000, 6'h17), 32'h3000, 32'h0);
            chk(se === 1'b1 && ec === (k == 0 ? 3'h1 : k[2:0] + 3'h2), "fault");
        end
        sv = 1'b1;
        f = 5'h01;
        ld(fi(5'h01, 5'h06, 16'h0000, 6'h17), 32'h3000, 32'h3000, 32'hCFFF3000, 4'hF, 1'b0);
        sv = 1'b0;
        f = 5'h00;
        go(fi(5'h01, 5'h06, 16'h0000, 6'h3F), 32'h0, 32'h0);
        chk(sw === 1'b0 && se === 1'b0 && sw2 === 1'b0 && se2 === 1'b0, "unknown op");
        $display("fault test done");
        end_sim;
    end
endmodule // testbench
